//--- hdl/smcb_cfg.svh
// smcb_cfg.svh - constants of the serial module command block
//
// Notes on behaviour
// - quick-response load only on slave port
// - two words carry four quick-response bytes
// - keep quick response for quick-sequence polls
// - clear diagnostics needs block length one
// - twenty diagnostic words, read by 06003
// - diagnostics read moves one contiguous run
// - reconfiguration replaces power-up port settings
// - word 65535 leaves parameter unchanged
// - nine timers then three retry counts
// - mode 2 two-wire, 4 four-wire, default four
// - two-wire: receiver off while transmitting
// - receiver re-enable delay in milliseconds
// - remote reads fill register, input, output tables
// - target types 1,2,3,6,9
// - processor builds header words, command word seven
// - error 0f: quick load on non-slave
// - error 41: invalid command number
`ifndef SMCB_CFG_SVH
`define SMCB_CFG_SVH

// ------
// command block layout (zero-based word index)
// ------
`define SMCB_BLK_WORDS 21
`define SMCB_W_LEN 0
`define SMCB_W_CMD 6
`define SMCB_W_P8 7
`define SMCB_W_P9 8
`define SMCB_W_P10 9
`define SMCB_W_P11 10
`define SMCB_W_P12 11
`define SMCB_W_RETRY0 16
`define SMCB_W_MODE 19
`define SMCB_W_RXDLY 20

// ------
// command numbers and codes
// ------
`define SMCB_CMD_QLOAD 16'h1771
`define SMCB_CMD_DCLR 16'h1772
`define SMCB_CMD_DRD 16'h1773
`define SMCB_CMD_RCFG 16'h1774
`define SMCB_CMD_RRD_REG 16'h17d5
`define SMCB_CMD_RRD_OUT 16'h17d7
`define SMCB_KEEP 16'hffff
`define SMCB_MODE_2W 16'h0002
`define SMCB_MODE_4W 16'h0004
`define SMCB_DIAG_WORDS 20
`define SMCB_RETRY_MAX 16'h0032
`define SMCB_STS_OK 16'h0001
`define SMCB_STS_MAJ_ERR 8'h0c
`define SMCB_ERR_NOT_SLAVE 8'h0f
`define SMCB_ERR_BAD_CMD 8'h41
`define SMCB_ERR_BAD_LEN 8'h42
`define SMCB_ERR_RANGE 8'h48

// ------
// power-up port settings and timing
// ------
`define SMCB_TMR_RESET 16'h01f4
`define SMCB_RETRY_RESET 16'h0003
`define SMCB_RXDLY_RESET 16'h0000
`define SMCB_MS_NS 1000000
`define SMCB_CLK_NS 10
`define SMCB_MS_CYCLES (`SMCB_MS_NS / `SMCB_CLK_NS)

// ------
// host register map (byte addresses)
// ------
`define SMCB_A_BLK 12'h000
`define SMCB_A_CTRL 12'h080
`define SMCB_A_STAT 12'h084
`define SMCB_A_IRQ 12'h088
`define SMCB_A_MASK 12'h08c
`define SMCB_A_TAB 12'h100
`define SMCB_TAB_WORDS 64

`endif

//--- hdl/smcb_pkg.sv
// smcb_pkg.sv - types of the serial module command block
package smcb_pkg;
  typedef logic [15:0] smcb_word_t;
  typedef smcb_word_t smcb_timers_t [0:8];
  typedef smcb_word_t smcb_retries_t [0:2];
  typedef enum logic [1:0] {
    SMCB_TAB_REG = 2'h0,
    SMCB_TAB_IN = 2'h1,
    SMCB_TAB_OUT = 2'h2
  } smcb_table_t;
endpackage

//--- hdl/smcb_if.sv
// smcb_if.sv - link between controller processor and serial module
`timescale 1ns/1ps
interface smcb_if;
  // command block words, word 1 first
  logic blk_valid;
  logic blk_ready;
  logic blk_last;
  smcb_pkg::smcb_word_t blk_data;
  // status word
  logic sts_valid;
  smcb_pkg::smcb_word_t sts_data;
  // data words into a controller table
  logic rd_valid;
  smcb_pkg::smcb_table_t rd_table;
  smcb_pkg::smcb_word_t rd_addr;
  smcb_pkg::smcb_word_t rd_data;

  modport proc (
    output blk_valid, blk_last, blk_data,
    input blk_ready, sts_valid, sts_data, rd_valid, rd_table, rd_addr, rd_data
  );
  modport module_end (
    input blk_valid, blk_last, blk_data,
    output blk_ready, sts_valid, sts_data, rd_valid, rd_table, rd_addr, rd_data
  );
endinterface

//--- hdl/smcb_serial_comm_module.sv
// smcb_serial_comm_module.sv - command interpreter of the serial comm module
`timescale 1ns/1ps
`include "smcb_cfg.svh"
module smcb_serial_comm_module #(
  parameter int MS_CYCLES = `SMCB_MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // processor side
  smcb_if.module_end cb,
  // port strap and diagnostics events
  input wire logic slave_pin,
  input wire logic diag_inc_valid,
  input wire logic [4:0] diag_inc_idx,
  // quick response presented to the link
  output logic q_loaded,
  output logic [31:0] q_resp,
  // port configuration
  output smcb_pkg::smcb_timers_t port_timers,
  output smcb_pkg::smcb_retries_t port_retries,
  output logic two_wire,
  // rs-485 transceiver
  input wire logic tx_active,
  output logic rx_enable,
  // remote read towards the link engine
  output logic rr_valid,
  input wire logic rr_ready,
  output logic [15:0] rr_target,
  output logic [15:0] rr_type,
  output logic [15:0] rr_addr,
  output logic [15:0] rr_len,
  input wire logic rr_data_valid,
  input wire logic [15:0] rr_data,
  input wire logic rr_done,
  input wire logic [7:0] rr_err
);

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_LOAD = 6'b000010,
    S_EXEC = 6'b000100,
    S_DIAG = 6'b001000,
    S_REMOTE = 6'b010000,
    S_STS = 6'b100000
  } smcb_state_t;

  smcb_state_t state_reg;
  smcb_pkg::smcb_word_t blk_reg [0:`SMCB_BLK_WORDS-1];
  smcb_pkg::smcb_word_t diag_reg [0:`SMCB_DIAG_WORDS-1];
  logic [4:0] widx_reg;
  logic [15:0] sts_reg;
  logic [15:0] xfer_idx_reg;
  logic [15:0] xfer_left_reg;
  logic [15:0] dest_reg;
  logic sts_valid_reg;
  logic rd_valid_reg;
  logic [15:0] rd_addr_reg;
  logic [15:0] rd_data_reg;
  smcb_pkg::smcb_table_t rd_table_reg;
  logic slave_m_reg;
  logic slave_s_reg;
  logic tx_d_reg;
  logic [15:0] rxdly_reg;
  logic [15:0] dly_left_reg;
  logic [31:0] ms_cnt_reg;

  // a parameter word of 65535 keeps the present setting
  function automatic logic [15:0] keep_or(input logic [15:0] cur, input logic [15:0] w);
    keep_or = (w == `SMCB_KEEP) ? cur : w;
  endfunction

  function automatic logic [15:0] err_word(input logic [7:0] code);
    err_word = {code, `SMCB_STS_MAJ_ERR};
  endfunction

  wire [15:0] cmd = blk_reg[`SMCB_W_CMD];
  wire [15:0] p9 = blk_reg[`SMCB_W_P9];
  wire [15:0] p10 = blk_reg[`SMCB_W_P10];
  wire [15:0] p11 = blk_reg[`SMCB_W_P11];
  wire [15:0] mode_w = blk_reg[`SMCB_W_MODE];
  wire is_remote = (cmd >= `SMCB_CMD_RRD_REG) && (cmd <= `SMCB_CMD_RRD_OUT);
  wire type_ok = (p9 == 16'h0001) || (p9 == 16'h0002) || (p9 == 16'h0003) ||
                 (p9 == 16'h0006) || (p9 == 16'h0009);
  wire [16:0] diag_end = {1'b0, p10} + {1'b0, p11} - 17'h00001;
  wire diag_ok = (p10 != 16'h0000) && (p11 != 16'h0000) &&
                 (diag_end <= 17'(`SMCB_DIAG_WORDS));
  wire mode_ok = (mode_w == `SMCB_MODE_2W) || (mode_w == `SMCB_MODE_4W) ||
                 (mode_w == `SMCB_KEEP);

  logic retry_ok;
  always_comb begin
    retry_ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (blk_reg[`SMCB_W_RETRY0+i] != `SMCB_KEEP &&
          blk_reg[`SMCB_W_RETRY0+i] > `SMCB_RETRY_MAX) begin
        retry_ok = 1'b0;
      end
    end
  end

  assign cb.blk_ready = (state_reg == S_IDLE) || (state_reg == S_LOAD);
  assign cb.sts_valid = sts_valid_reg;
  assign cb.sts_data = sts_reg;
  assign cb.rd_valid = rd_valid_reg;
  assign cb.rd_addr = rd_addr_reg;
  assign cb.rd_data = rd_data_reg;
  assign cb.rd_table = rd_table_reg;
  assign rr_valid = (state_reg == S_REMOTE) && (xfer_idx_reg == 16'h0000);
  assign rr_target = blk_reg[`SMCB_W_P8];
  assign rr_type = p9;
  assign rr_addr = p10;
  assign rr_len = p11;

  // ------
  // slave strap synchroniser
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slave_m_reg <= 1'b0;
      slave_s_reg <= 1'b0;
    end else begin
      slave_m_reg <= slave_pin;
      slave_s_reg <= slave_m_reg;
    end
  end

  // ------
  // command sequencer
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      widx_reg <= 5'h00;
      sts_reg <= 16'h0000;
      sts_valid_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_addr_reg <= 16'h0000;
      rd_data_reg <= 16'h0000;
      rd_table_reg <= smcb_pkg::SMCB_TAB_REG;
      xfer_idx_reg <= 16'h0000;
      xfer_left_reg <= 16'h0000;
      dest_reg <= 16'h0000;
      for (int i = 0; i < `SMCB_BLK_WORDS; i++) begin
        blk_reg[i] <= 16'h0000;
      end
    end else begin
      sts_valid_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      case (state_reg)
        S_IDLE, S_LOAD: begin
          if (cb.blk_valid) begin
            // words past the last one leave stale contents; only the clear command checks the block length
            if (widx_reg < 5'(`SMCB_BLK_WORDS)) begin
              blk_reg[widx_reg] <= cb.blk_data;
            end
            widx_reg <= widx_reg + 5'h01;
            state_reg <= cb.blk_last ? S_EXEC : S_LOAD;
          end
        end
        S_EXEC: begin
          widx_reg <= 5'h00;
          sts_reg <= `SMCB_STS_OK;
          state_reg <= S_STS;
          case (cmd)
            `SMCB_CMD_QLOAD: begin
              if (!slave_s_reg) begin
                sts_reg <= err_word(`SMCB_ERR_NOT_SLAVE);
              end
            end
            `SMCB_CMD_DCLR: begin
              if (blk_reg[`SMCB_W_LEN] != 16'h0001) begin
                sts_reg <= err_word(`SMCB_ERR_BAD_LEN);
              end
            end
            `SMCB_CMD_DRD: begin
              if (!diag_ok) begin
                sts_reg <= err_word(`SMCB_ERR_RANGE);
              end else begin
                xfer_idx_reg <= p10 - 16'h0001;
                xfer_left_reg <= p11;
                dest_reg <= blk_reg[`SMCB_W_P12];
                state_reg <= S_DIAG;
              end
            end
            `SMCB_CMD_RCFG: begin
              if (!mode_ok || !retry_ok) begin
                sts_reg <= err_word(`SMCB_ERR_RANGE);
              end
            end
            default: begin
              if (!is_remote) begin
                sts_reg <= err_word(`SMCB_ERR_BAD_CMD);
              end else if (!type_ok) begin
                sts_reg <= err_word(`SMCB_ERR_RANGE);
              end else begin
                xfer_idx_reg <= 16'h0000;
                dest_reg <= blk_reg[`SMCB_W_P12];
                rd_table_reg <= smcb_pkg::smcb_table_t'(2'(cmd - `SMCB_CMD_RRD_REG));
                state_reg <= S_REMOTE;
              end
            end
          endcase
        end
        S_DIAG: begin
          rd_valid_reg <= 1'b1;
          rd_table_reg <= smcb_pkg::SMCB_TAB_REG;
          rd_data_reg <= diag_reg[5'(xfer_idx_reg)];
          rd_addr_reg <= dest_reg;
          dest_reg <= dest_reg + 16'h0001;
          xfer_idx_reg <= xfer_idx_reg + 16'h0001;
          xfer_left_reg <= xfer_left_reg - 16'h0001;
          if (xfer_left_reg == 16'h0001) begin
            state_reg <= S_STS;
          end
        end
        S_REMOTE: begin
          if (rr_valid && rr_ready) begin
            xfer_idx_reg <= 16'h0001;
          end
          if (rr_data_valid && xfer_idx_reg != 16'h0000) begin
            rd_valid_reg <= 1'b1;
            rd_data_reg <= rr_data;
            rd_addr_reg <= dest_reg;
            dest_reg <= dest_reg + 16'h0001;
          end
          if (rr_done && xfer_idx_reg != 16'h0000) begin
            sts_reg <= (rr_err == 8'h00) ? `SMCB_STS_OK : err_word(rr_err);
            state_reg <= S_STS;
          end
        end
        S_STS: begin
          sts_valid_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  wire exec_ok = (state_reg == S_EXEC);

  // ------
  // quick response
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_loaded <= 1'b0;
      q_resp <= 32'h00000000;
    end else if (exec_ok && cmd == `SMCB_CMD_QLOAD && slave_s_reg) begin
      q_loaded <= 1'b1;
      q_resp <= {p9, blk_reg[`SMCB_W_P8]}; // byte 1 in bits 7:0
    end
  end

  // ------
  // diagnostic status words
  // ------
  wire diag_clr = exec_ok && cmd == `SMCB_CMD_DCLR && blk_reg[`SMCB_W_LEN] == 16'h0001;
  generate
    for (genvar g = 0; g < `SMCB_DIAG_WORDS; g++) begin : g_diag
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          diag_reg[g] <= 16'h0000;
        end else if (diag_inc_valid && diag_inc_idx == 5'(g)) begin
          // an event in the clearing cycle is kept as the first count
          diag_reg[g] <= diag_clr ? 16'h0001 : diag_reg[g] + 16'h0001;
        end else if (diag_clr) begin
          diag_reg[g] <= 16'h0000;
        end
      end
    end
  endgenerate

  // ------
  // port reconfiguration
  // ------
  wire cfg_go = exec_ok && cmd == `SMCB_CMD_RCFG && mode_ok && retry_ok;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 9; i++) begin
        port_timers[i] <= `SMCB_TMR_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        port_retries[i] <= `SMCB_RETRY_RESET;
      end
      two_wire <= 1'b0;
      rxdly_reg <= `SMCB_RXDLY_RESET;
    end else if (cfg_go) begin
      for (int i = 0; i < 9; i++) begin
        port_timers[i] <= keep_or(port_timers[i], blk_reg[`SMCB_W_P8+i]);
      end
      for (int i = 0; i < 3; i++) begin
        port_retries[i] <= keep_or(port_retries[i], blk_reg[`SMCB_W_RETRY0+i]);
      end
      if (mode_w != `SMCB_KEEP) begin
        two_wire <= (mode_w == `SMCB_MODE_2W);
      end
      rxdly_reg <= keep_or(rxdly_reg, blk_reg[`SMCB_W_RXDLY]);
    end
  end

  // ------
  // rs-485 receiver turnaround
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_d_reg <= 1'b0;
      dly_left_reg <= 16'h0000;
      ms_cnt_reg <= 32'h00000000;
    end else begin
      tx_d_reg <= tx_active;
      if (tx_active) begin
        dly_left_reg <= 16'h0000;
      end else if (tx_d_reg) begin
        dly_left_reg <= rxdly_reg; // delay starts as transmission ends
        ms_cnt_reg <= 32'h00000000;
      end else if (dly_left_reg != 16'h0000) begin
        if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
          ms_cnt_reg <= 32'h00000000;
          dly_left_reg <= dly_left_reg - 16'h0001;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
        end
      end
    end
  end

  assign rx_enable = !two_wire ||
                     (!tx_active && !tx_d_reg && dly_left_reg == 16'h0000);

endmodule

//--- hdl/smcb_proc_end.sv
// smcb_proc_end.sv - processor end: avalon registers to command blocks
`timescale 1ns/1ps
`include "smcb_cfg.svh"
module smcb_proc_end (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // module link
  smcb_if.proc cb
);

  smcb_pkg::smcb_word_t blk_mem [0:`SMCB_BLK_WORDS-1];
  smcb_pkg::smcb_word_t tab_mem [0:`SMCB_TAB_WORDS-1];
  logic busy_reg;
  logic [4:0] len_reg;
  logic [4:0] sidx_reg;
  logic sending_reg;
  logic [15:0] last_sts_reg;
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_mask_reg;
  logic ack_reg;

  wire acc = (avs_read || avs_write) && !ack_reg;
  wire wr = avs_write && ack_reg;
  wire go = wr && avs_address == `SMCB_A_CTRL && avs_writedata[0] && !busy_reg;
  wire blk_sel = avs_address < 12'(`SMCB_BLK_WORDS * 4);

  // answer one cycle after the request appears
  assign avs_waitrequest = acc;
  assign irq = |(irq_sts_reg & irq_mask_reg);
  assign cb.blk_valid = sending_reg;
  assign cb.blk_data = blk_mem[sidx_reg]; // word 1 first
  assign cb.blk_last = sending_reg && (sidx_reg == len_reg);

  // ------
  // register file
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
      irq_mask_reg <= 2'h0;
      for (int i = 0; i < `SMCB_BLK_WORDS; i++) begin
        blk_mem[i] <= 16'h0000;
      end
    end else begin
      ack_reg <= acc;
      if (acc && avs_read) begin
        avs_readdata <= 32'h00000000;
        if (blk_sel) begin
          avs_readdata <= {16'h0000, blk_mem[5'(avs_address[11:2])]};
        end else if (avs_address == `SMCB_A_STAT) begin
          avs_readdata <= {last_sts_reg, 15'h0000, busy_reg};
        end else if (avs_address == `SMCB_A_IRQ) begin
          avs_readdata <= {30'h00000000, irq_sts_reg};
        end else if (avs_address == `SMCB_A_MASK) begin
          avs_readdata <= {30'h00000000, irq_mask_reg};
        end else if (avs_address >= `SMCB_A_TAB) begin
          avs_readdata <= {16'h0000, tab_mem[6'(avs_address[11:2])]};
        end
      end
      if (wr && blk_sel && !busy_reg) begin
        blk_mem[5'(avs_address[11:2])] <= avs_writedata[15:0];
      end
      if (wr && avs_address == `SMCB_A_MASK) begin
        irq_mask_reg <= avs_writedata[1:0];
      end
    end
  end

  // ------
  // block transmission and completion
  // ------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      sending_reg <= 1'b0;
      len_reg <= 5'h00;
      sidx_reg <= 5'h00;
      last_sts_reg <= 16'h0000;
      irq_sts_reg <= 2'h0;
    end else begin
      if (go) begin
        busy_reg <= 1'b1;
        sending_reg <= 1'b1;
        sidx_reg <= 5'h00;
        // header is six words plus the data block length
        len_reg <= 5'(blk_mem[`SMCB_W_LEN] + 16'h0005);
      end else if (sending_reg && cb.blk_ready) begin
        sidx_reg <= sidx_reg + 5'h01;
        if (cb.blk_last) begin
          sending_reg <= 1'b0;
        end
      end
      // set wins over a write-one clear in the same cycle
      for (int i = 0; i < 2; i++) begin
        if (wr && avs_address == `SMCB_A_IRQ && avs_writedata[i]) begin
          irq_sts_reg[i] <= 1'b0;
        end
      end
      if (cb.sts_valid) begin
        busy_reg <= 1'b0;
        last_sts_reg <= cb.sts_data;
        irq_sts_reg[0] <= 1'b1;
        if (cb.sts_data != `SMCB_STS_OK) begin
          irq_sts_reg[1] <= 1'b1;
        end
      end
    end
  end

  // data words from the module land in a small local table
  always_ff @(posedge clock) begin
    if (cb.rd_valid) begin
      tab_mem[6'(cb.rd_addr)] <= cb.rd_data;
    end
  end

endmodule

//--- tb/smcb_asserts.sv
// assertions on the processor-to-module link
`timescale 1ns/1ps
`include "smcb_cfg.svh"
module smcb_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link signals
  input wire logic blk_valid,
  input wire logic blk_ready,
  input wire logic blk_last,
  input wire smcb_pkg::smcb_word_t blk_data,
  input wire logic sts_valid,
  input wire smcb_pkg::smcb_word_t sts_data,
  input wire logic rd_valid,
  input wire smcb_pkg::smcb_table_t rd_table,
  input wire smcb_pkg::smcb_word_t rd_addr,
  input wire smcb_pkg::smcb_word_t rd_data
);
  logic tk;
  logic rmt;
  logic [15:0] wn_reg, len_reg, cmd_reg, dst_reg, rn_reg, cmd;
  assign tk = blk_valid && blk_ready;
  // the command word may be the last word itself
  assign cmd = (wn_reg == 16'h0006) ? blk_data : cmd_reg;
  assign rmt = cmd_reg >= `SMCB_CMD_RRD_REG && cmd_reg <= `SMCB_CMD_RRD_OUT;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wn_reg <= '0;
      len_reg <= '0;
      cmd_reg <= '0;
      dst_reg <= '0;
      rn_reg <= '0;
    end else begin
      if (tk) wn_reg <= blk_last ? 16'h0000 : wn_reg + 16'h0001;
      if (tk && wn_reg == 16'h0000) len_reg <= blk_data;
      if (tk && wn_reg == 16'h0006) cmd_reg <= blk_data;
      if (tk && wn_reg == 16'h000b) dst_reg <= blk_data;
      if (tk) rn_reg <= '0;
      else if (rd_valid) rn_reg <= rn_reg + 16'h0001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff rst;
  sequence s_last;
    tk && blk_last;
  endsequence
  property p_sts_pulse;
    sts_valid |=> !sts_valid;
  endproperty
  a_sts_pulse: assert property (p_sts_pulse)
    else $error("status pulse too long");
  property p_last_len;
    s_last |-> wn_reg == len_reg + 16'h0005;
  endproperty
  a_last_len: assert property (p_last_len)
    else $error("last word misplaced");
  property p_ready_exec;
    s_last |=> !blk_ready;
  endproperty
  a_ready_exec: assert property (p_ready_exec)
    else $error("ready during execution");
  property p_local_ans;
    s_last ##0 (cmd inside {`SMCB_CMD_QLOAD, `SMCB_CMD_DCLR, `SMCB_CMD_RCFG}) |-> ##3 sts_valid;
  endproperty
  a_local_ans: assert property (p_local_ans)
    else $error("local command answer late");
  property p_clr_ok;
    s_last ##0 (cmd == `SMCB_CMD_DCLR && len_reg == 16'h0001)
      |-> ##3 sts_valid && sts_data == `SMCB_STS_OK;
  endproperty
  a_clr_ok: assert property (p_clr_ok)
    else $error("clear not accepted");
  property p_bad_cmd;
    s_last ##0 !(cmd inside {[`SMCB_CMD_QLOAD:`SMCB_CMD_RCFG],
      [`SMCB_CMD_RRD_REG:`SMCB_CMD_RRD_OUT]})
      |-> ##3 sts_valid && sts_data == {`SMCB_ERR_BAD_CMD, `SMCB_STS_MAJ_ERR};
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("bad command not refused");
  property p_rd_table;
    rd_valid && rmt |-> rd_table == cmd_reg[1:0] - 2'h1;
  endproperty
  a_rd_table: assert property (p_rd_table)
    else $error("wrong destination table");
  property p_rd_addr;
    rd_valid && rmt |-> rd_addr == dst_reg + rn_reg;
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("wrong destination address");
endmodule

//--- tb/tb.sv
// self-checking bench for the command block pair
`timescale 1ns/1ps
`include "smcb_cfg.svh"
module tb;
  logic clock, rst, rd, wr, slave_pin, inc, tx, rr_ready, rr_dv, rr_done;
  logic wt, irq, q_loaded, two_wire, rx_en, rr_valid;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, d, q_resp;
  logic [4:0] idx;
  logic [15:0] rr_data, tmr, rr_target, rr_type, rr_addr, rr_len;
  smcb_pkg::smcb_timers_t tmrs;
  smcb_pkg::smcb_retries_t rets;
  smcb_pkg::smcb_word_t blk [0:20];
  logic [15:0] expq [$];
  int num_errors, checks;
  int tys [5] = '{1, 2, 3, 6, 9};
  smcb_if lnk ();
  smcb_proc_end smcb_proc_end_inst (.clock(clock), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wt), .irq(irq), .cb(lnk.proc));
  smcb_serial_comm_module #(.MS_CYCLES(10)) smcb_serial_comm_module_inst (.clock(clock),
    .rst(rst), .cb(lnk.module_end), .slave_pin(slave_pin), .diag_inc_valid(inc),
    .diag_inc_idx(idx), .q_loaded(q_loaded), .q_resp(q_resp), .port_timers(tmrs),
    .port_retries(rets), .two_wire(two_wire), .tx_active(tx), .rx_enable(rx_en),
    .rr_valid(rr_valid), .rr_ready(rr_ready), .rr_target(rr_target), .rr_type(rr_type),
    .rr_addr(rr_addr), .rr_len(rr_len), .rr_data_valid(rr_dv), .rr_data(rr_data),
    .rr_done(rr_done), .rr_err(8'h00));
  smcb_asserts smcb_asserts_inst (.clock(clock), .rst(rst), .blk_valid(lnk.blk_valid),
    .blk_ready(lnk.blk_ready), .blk_last(lnk.blk_last), .blk_data(lnk.blk_data),
    .sts_valid(lnk.sts_valid), .sts_data(lnk.sts_data), .rd_valid(lnk.rd_valid),
    .rd_table(lnk.rd_table), .rd_addr(lnk.rd_addr), .rd_data(lnk.rd_data));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] er(input logic [7:0] c);
    return {c, `SMCB_STS_MAJ_ERR};
  endfunction
  // one avalon transfer; the watchdog bounds the wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clock); while (wt !== 1'b0);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic run(input int len, input logic [15:0] exp);
    blk[0] = 16'(len);
    for (int i = 0; i < len + 6; i++) bus(1, 12'(4 * i), {16'h0, blk[i]});
    expq.push_back(exp);
    bus(1, `SMCB_A_CTRL, 32'h1);
    do bus(0, `SMCB_A_STAT, 0); while (d[0] !== 1'b0);
  endtask
  // status monitor pairs each status pulse with the oldest note
  always @(posedge clock) begin
    if (lnk.sts_valid === 1'b1) begin
      if (expq.size() == 0) chk("extra status", 1, 0);
      else chk("status", {16'h0, lnk.sts_data}, {16'h0, expq.pop_front()});
    end
  end
  // link engine: stalls a random while before taking the request
  initial begin
    forever begin
      @(posedge clock);
      if (rr_valid === 1'b1) begin
        chk("target", {16'h0, rr_target}, 32'h24);
        chk("type", {16'h0, rr_type}, {16'h0, blk[8]});
        chk("len", {16'h0, rr_len}, 32'h2);
        chk("addr", {16'h0, rr_addr}, 32'h1);
        repeat ($urandom_range(3)) @(posedge clock);
        rr_ready <= 1;
        @(posedge clock);
        rr_ready <= 0;
        for (int n = 0; n < 2; n++) begin
          rr_dv <= 1;
          rr_data <= 16'h5a00 + 16'(n);
          @(posedge clock);
        end
        rr_dv <= 0;
        rr_done <= 1;
        @(posedge clock);
        rr_done <= 0;
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    test_done();
  end
  initial begin
    {rd, wr, adr, wdat, slave_pin, inc, idx, tx, rr_ready, rr_dv, rr_data, rr_done} = '0;
    blk = '{default: 16'h0};
    blk[2] = 16'h0008;
    blk[3] = 16'h0009;
    rst = 1;
    void'($urandom(51590));
    repeat (10) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    chk("timer reset", {16'h0, tmrs[0]}, {16'h0, `SMCB_TMR_RESET});
    chk("rx reset", 32'(rx_en), 1);
    blk[6] = `SMCB_CMD_QLOAD;
    blk[7] = 16'($urandom);
    blk[8] = 16'($urandom);
    run(3, er(`SMCB_ERR_NOT_SLAVE));
    chk("no load", 32'(q_loaded), 0);
    slave_pin <= 1;
    run(3, `SMCB_STS_OK);
    chk("quick", q_resp, {blk[8], blk[7]});
    blk[6] = `SMCB_CMD_DCLR;
    run(2, er(`SMCB_ERR_BAD_LEN));
    run(1, `SMCB_STS_OK);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      inc <= 1;
      idx <= (i == 2) ? 5'h13 : 5'h00;
    end
    @(posedge clock);
    inc <= 0;
    blk[6] = `SMCB_CMD_DRD;
    blk[9] = 0;
    blk[10] = 20;
    run(6, er(`SMCB_ERR_RANGE));
    blk[9] = 1;
    run(6, `SMCB_STS_OK);
    blk[9] = 20;
    blk[10] = 1;
    blk[11] = 30;
    run(6, `SMCB_STS_OK);
    for (int k = 0; k < 21; k++) begin
      bus(0, 12'(`SMCB_A_TAB + 4 * (k == 20 ? 30 : k)), 0);
      chk("diag", {16'h0, d[15:0]}, (k == 0) ? 2 : (k > 18) ? 1 : 0);
    end
    blk[6] = `SMCB_CMD_RCFG;
    for (int i = 7; i < 21; i++) blk[i] = `SMCB_KEEP;
    tmr = 16'($urandom_range(65534));
    blk[7] = tmr;
    blk[15] = 0;
    blk[18] = 51;
    run(15, er(`SMCB_ERR_RANGE));
    chk("kept", {16'h0, tmrs[0]}, {16'h0, `SMCB_TMR_RESET});
    blk[16] = 16;
    blk[18] = 50;
    blk[19] = `SMCB_MODE_2W;
    blk[20] = 1;
    run(15, `SMCB_STS_OK);
    chk("tmr0", {16'h0, tmrs[0]}, {16'h0, tmr});
    chk("tmr1", {16'h0, tmrs[1]}, {16'h0, `SMCB_TMR_RESET});
    chk("tmr8", {16'h0, tmrs[8]}, 0);
    chk("rets", {rets[0], rets[1]}, {16'h10, `SMCB_RETRY_RESET});
    chk("ret2", {16'h0, rets[2]}, 32'h32);
    chk("2w", 32'(two_wire), 1);
    tx <= 1;
    repeat (3) @(posedge clock);
    chk("rx tx", 32'(rx_en), 0);
    tx <= 0;
    repeat (8) @(posedge clock);
    chk("rx dly", 32'(rx_en), 0);
    repeat (6) @(posedge clock);
    chk("rx on", 32'(rx_en), 1);
    blk[19] = `SMCB_MODE_4W;
    run(15, `SMCB_STS_OK);
    tx <= 1;
    @(posedge clock);
    @(posedge clock);
    chk("4w rx", 32'(rx_en), 1);
    tx <= 0;
    for (int c = 0; c < 6; c++) begin
      blk[6] = `SMCB_CMD_RRD_REG + 16'(c % 3);
      blk[7] = 16'h0024;
      blk[8] = (c == 5) ? 16'h4 : 16'(tys[c]);
      blk[9] = 1;
      blk[10] = 2;
      blk[11] = 16'(40 + 4 * c);
      run(6, (c == 5) ? er(`SMCB_ERR_RANGE) : `SMCB_STS_OK);
      for (int k = 0; k < 2 && c < 5; k++) begin
        bus(0, 12'(`SMCB_A_TAB + 4 * (40 + 4 * c + k)), 0);
        chk("remote", {16'h0, d[15:0]}, 32'h5a00 + k);
      end
    end
    blk[6] = 16'h17d8;
    run(6, er(`SMCB_ERR_BAD_CMD));
    chk("irq masked", 32'(irq), 0);
    bus(1, `SMCB_A_MASK, 32'h3);
    @(posedge clock);
    chk("irq on", 32'(irq), 1);
    bus(1, `SMCB_A_IRQ, 32'h3);
    bus(0, `SMCB_A_IRQ, 0);
    chk("irq clear", {d[31:2], irq, d[0]}, 0);
    bus(0, 12'h0c0, 0);
    chk("unmapped", d, 0);
    repeat (4) @(posedge clock);
    chk("pending", 32'(expq.size()), 0);
    test_done();
  end
endmodule
